// ==== src/mcu_exec_core.sv ====
/*
 * Execution unit for load-immediate, no-op, move, the two returns and rotate-left,
 * with a 128-byte data register file, return stack and an AXI4-Lite control/status slave.
 * Assumes an instruction source on aclk that holds instr_* until instr_ready and drops
 * its prefetched word whenever instr_flush is high.
 */
// Function
// - load literal into accumulator, flags untouched
// - no-op only advances pc by one
// - move copies register to accumulator or writes it back to itself
// - move sets zero flag from moved value
// - return-enable loads pc, sets interrupt enable
// - return-literal loads accumulator and pc
// - both returns pop the stack once
// - rotate left through carry, bit7 to carry
// - rotate result to accumulator or register
`timescale 1ns/1ps
`include "ops_consts.svh"

module mcu_exec_core #(
    parameter int PC_W = 11,
    parameter int STACK_DEPTH = 8,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic instr_valid,
    input wire core_ops_pkg::op_t instr_op,
    input wire logic [6:0] instr_reg,
    input wire logic instr_dest,
    input wire logic [7:0] instr_lit,
    output logic instr_ready,
    output logic instr_flush,
    output logic [PC_W-1:0] pc,
    output logic [7:0] accumulator_reg,
    output logic global_interrupt_enable
);
    import core_ops_pkg::*;

    localparam int LW = $clog2(STACK_DEPTH + 1);

    logic [7:0] data_regs [128];
    logic carry, zero, run;
    state_t state, next_state;
    logic [7:0] next_acc;
    logic next_carry, next_zero, next_int_enable, next_ready, next_flush, next_run;
    logic [PC_W-1:0] next_pc;
    logic mem_we;
    logic [7:0] mem_data;
    logic pop;
    logic take, is_ret;
    logic [7:0] r_value, rot_result;
    logic rot_carry, is_zero;
    logic [PC_W-1:0] stack_top;
    logic [LW-1:0] stack_level;
    // bus state
    logic aw_have, w_have, next_aw_have, next_w_have;
    logic [ADDR_W-1:0] wr_addr, next_wr_addr;
    logic [31:0] wr_data, next_wr_data;
    logic [3:0] wr_strb, next_wr_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_write, wr_lo, sw_ctrl_wr, sw_status_wr, sw_push;

    assign r_value = data_regs[instr_reg];
    assign take = instr_valid && instr_ready;
    assign is_ret = (instr_op == return_enable_interrupts) || (instr_op == return_with_literal);

    move_rotate_unit u_rot (
        .r_value(r_value),
        .carry_in(carry),
        .rot_result(rot_result),
        .rot_carry(rot_carry),
        .is_zero(is_zero)
    );

    return_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W), .LW(LW)) u_stack (
        .aclk(aclk),
        .aresetn(aresetn),
        .push(sw_push),
        .push_data(wr_data[PC_W-1:0]),
        .pop(pop),
        .top(stack_top),
        .level(stack_level)
    );

    // instruction execution: one cycle for all but the returns
    always_comb begin
        next_acc = accumulator_reg;
        next_carry = carry;
        next_zero = zero;
        next_int_enable = global_interrupt_enable;
        next_pc = pc;
        next_state = st_exec;
        next_flush = 1'b0;
        mem_we = 1'b0;
        mem_data = r_value;
        pop = 1'b0;
        // software flag writes lose only on the flags that an instruction or return in the same cycle sets
        if (sw_status_wr) begin
            next_carry = wr_data[`ST_C];
            next_zero = wr_data[`ST_Z];
            next_int_enable = wr_data[`ST_IE];
        end
        if (state == st_ret_second) begin
            next_state = st_exec;
        end else if (take) begin
            next_pc = PC_W'(pc + 1'b1);
            case (instr_op)
                load_immediate_to_acc: begin
                    next_acc = instr_lit;
                end
                no_operation: begin
                end
                move_register: begin
                    if (instr_dest) begin
                        mem_we = 1'b1;
                    end else begin
                        next_acc = r_value;
                    end
                    next_zero = is_zero;
                end
                return_enable_interrupts: begin
                    next_pc = stack_top;
                    next_int_enable = 1'b1;
                    pop = 1'b1;
                    next_state = st_ret_second;
                    next_flush = 1'b1;
                end
                return_with_literal: begin
                    next_acc = instr_lit;
                    next_pc = stack_top;
                    pop = 1'b1;
                    next_state = st_ret_second;
                    next_flush = 1'b1;
                end
                rotate_left_through_carry: begin
                    mem_data = rot_result;
                    if (instr_dest) begin
                        mem_we = 1'b1;
                    end else begin
                        next_acc = rot_result;
                    end
                    next_carry = rot_carry;
                end
                default: begin
                    next_pc = pc;
                end
            endcase
        end
        // the bubble cycle refuses the next word so the popped address is fetched fresh
        next_ready = next_run && (next_state == st_exec);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accumulator_reg <= `RST_ACC;
            carry <= `RST_FLAG;
            zero <= `RST_FLAG;
            global_interrupt_enable <= `RST_FLAG;
            pc <= '0;
            state <= st_exec;
            instr_ready <= 1'b0;
            instr_flush <= 1'b0;
        end else begin
            accumulator_reg <= next_acc;
            carry <= next_carry;
            zero <= next_zero;
            global_interrupt_enable <= next_int_enable;
            pc <= next_pc;
            state <= next_state;
            instr_ready <= next_ready;
            instr_flush <= next_flush;
        end
    end

    // data register file: no reset, software must initialise before reading
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            data_regs[instr_reg] <= mem_data;
        end
    end

    // write channel: address and data captured in either order, applied together
    always_comb begin
        next_aw_have = aw_have;
        next_w_have = w_have;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (awvalid && awready) begin
            next_aw_have = 1'b1;
            next_wr_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_have = 1'b1;
            next_wr_data = wdata;
            next_wr_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            case (wr_addr)
                `OFS_CTRL, `OFS_STATUS, `OFS_PUSH: next_bresp = `RESP_OKAY;
                default: next_bresp = `RESP_SLVERR;
            endcase
        end
        next_awready = !next_aw_have;
        next_wready = !next_w_have;
    end

    // write effects; fields live in byte 0 (push also in byte 1)
    assign do_write = aw_have && w_have && !bvalid;
    assign wr_lo = do_write && wr_strb[0];
    assign sw_ctrl_wr = wr_lo && (wr_addr == `OFS_CTRL);
    assign sw_status_wr = wr_lo && (wr_addr == `OFS_STATUS);
    assign sw_push = wr_lo && wr_strb[1] && (wr_addr == `OFS_PUSH);
    assign next_run = sw_ctrl_wr ? wr_data[`CTRL_RUN] : run;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            wr_addr <= '0;
            wr_data <= 32'h0;
            wr_strb <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            run <= `RST_RUN;
        end else begin
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            run <= next_run;
        end
    end

    // read channel: one read in flight, data latched with rvalid
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata = 32'h0;
            next_rresp = `RESP_OKAY;
            case (araddr)
                `OFS_CTRL: next_rdata[`CTRL_RUN] = run;
                `OFS_STATUS: begin
                    next_rdata[`ST_C] = carry;
                    next_rdata[`ST_Z] = zero;
                    next_rdata[`ST_IE] = global_interrupt_enable;
                    next_rdata[`ST_LVL_LO +: LW] = stack_level;
                end
                `OFS_ACC: next_rdata[7:0] = accumulator_reg;
                `OFS_PC: next_rdata[PC_W-1:0] = pc;
                `OFS_PUSH: next_rdata[PC_W-1:0] = stack_top;
                default: next_rresp = `RESP_SLVERR;
            endcase
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `RESP_OKAY;
            arready <= 1'b0;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            arready <= next_arready;
        end
    end

    // checks on the execution behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence ret_taken;
        take && is_ret;
    endsequence

    sequence ret_bubble;
        !instr_ready && instr_flush && (state == st_ret_second);
    endsequence

    chk_load_acc_value: assert property (
        take && !sw_status_wr && instr_op == load_immediate_to_acc |=> accumulator_reg == $past(instr_lit)
            && $stable(carry) && $stable(zero))
        else $error("load immediate did not land in accumulator");

    chk_nop_pc_step: assert property (
        take && !sw_status_wr && instr_op == no_operation |=> pc == PC_W'($past(pc) + 1'b1)
            && $stable(accumulator_reg) && $stable(carry) && $stable(zero))
        else $error("no-op changed state or pc step wrong");

    chk_move_dest: assert property (
        take && instr_op == move_register && !instr_dest |=> accumulator_reg == $past(r_value))
        else $error("move to accumulator wrong");

    chk_move_zero: assert property (
        take && instr_op == move_register |=> zero == ($past(r_value) == 8'h00))
        else $error("move zero flag wrong");

    chk_ret_enable_ie: assert property (
        take && !sw_status_wr && instr_op == return_enable_interrupts |=> global_interrupt_enable
            && pc == $past(stack_top) && $stable(carry) && $stable(zero))
        else $error("return-enable did not load pc or set enable");

    chk_ret_lit_acc: assert property (
        take && !sw_status_wr && instr_op == return_with_literal |=> accumulator_reg == $past(instr_lit)
            && pc == $past(stack_top) && $stable(zero))
        else $error("return-literal result wrong");

    chk_ret_pop_level: assert property (
        ret_taken and (stack_level != '0) and !sw_push |=> stack_level == LW'($past(stack_level) - 1'b1))
        else $error("return did not pop stack");

    chk_rotate_carry_acc: assert property (
        take && !sw_status_wr && instr_op == rotate_left_through_carry && !instr_dest
            |=> carry == $past(r_value[7])
            && accumulator_reg == {$past(r_value[6:0]), $past(carry)} && $stable(zero))
        else $error("rotate left result or carry wrong");

    chk_rotate_reg_dest: assert property (
        take && instr_op == rotate_left_through_carry && instr_dest |=> $stable(accumulator_reg)
            && pc == PC_W'($past(pc) + 1'b1))
        else $error("rotate to register touched accumulator");

    chk_ret_discard_fetch: assert property (
        ret_taken |=> ret_bubble ##1 (state == st_exec && !instr_flush))
        else $error("return bubble missing");

endmodule : mcu_exec_core

// ==== shared/ops_consts.svh ====
/*
 * Offsets, field positions and reset values for the move/return/rotate execution block.
 * Assumes the includer works on a 32-bit AXI4-Lite data path with byte addresses.
 */
`ifndef OPS_CONSTS_SVH
`define OPS_CONSTS_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_ACC 8'h08
`define OFS_PC 8'h0c
`define OFS_PUSH 8'h10

// field positions
`define CTRL_RUN 0
`define ST_C 0
`define ST_Z 1
`define ST_IE 2
`define ST_LVL_LO 4

// reset values
`define RST_RUN 1'b1
`define RST_ACC 8'h00
`define RST_FLAG 1'b0

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== shared/core_ops_pkg.sv ====
/*
 * Types shared by the execution block: instruction selector and sequencer state.
 * Assumes the instruction source encodes operations with op_t directly.
 */
package core_ops_pkg;

    typedef enum logic [2:0] {
        load_immediate_to_acc = 3'h0,
        no_operation = 3'h1,
        move_register = 3'h2,
        return_enable_interrupts = 3'h3,
        return_with_literal = 3'h4,
        rotate_left_through_carry = 3'h5
    } op_t;

    // gray along exec -> second return cycle -> exec
    typedef enum logic [1:0] {
        st_exec = 2'b00,
        st_ret_second = 2'b01
    } state_t;

endpackage : core_ops_pkg

// ==== src/return_stack.sv ====
/*
 * Hardware return stack with a level counter.
 * Assumes the caller never pushes and pops in a way it cannot reason about; a pop at level
 * zero leaves the level at zero, and a push when full is dropped.
 */
`timescale 1ns/1ps

module return_stack #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 11,
    parameter int LW = $clog2(DEPTH + 1)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] top,
    output logic [LW-1:0] level
);
    logic [WIDTH-1:0] entries [DEPTH];
    logic [LW-1:0] next_level;
    logic we;
    logic [LW-1:0] wr_idx;
    logic [LW-1:0] top_idx;

    // empty stack still presents entry 0; entries have no reset, so it is unknown until first written
    assign top_idx = (level == '0) ? '0 : LW'(level - 1'b1);
    assign top = entries[top_idx[$clog2(DEPTH)-1:0]];

    // pop then push in one cycle replaces the top entry
    always_comb begin
        next_level = level;
        we = 1'b0;
        wr_idx = level;
        if (push && pop && level != '0) begin
            we = 1'b1;
            wr_idx = top_idx;
        end else if (pop && level != '0) begin
            next_level = LW'(level - 1'b1);
        end else if (push && level != LW'(DEPTH)) begin
            we = 1'b1;
            next_level = LW'(level + 1'b1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= '0;
        end else begin
            level <= next_level;
        end
        if (we) begin
            entries[wr_idx[$clog2(DEPTH)-1:0]] <= push_data;
        end
    end
endmodule : return_stack

// ==== src/move_rotate_unit.sv ====
/*
 * Combinational datapath for the register move and the rotate-left through carry.
 * Assumes the caller picks the destination and decides which flags to keep.
 */
`timescale 1ns/1ps

module move_rotate_unit (
    input wire logic [7:0] r_value,
    input wire logic carry_in,
    output logic [7:0] rot_result,
    output logic rot_carry,
    output logic is_zero
);
    // old carry enters bit 0, bit 7 leaves as the new carry
    always_comb begin
        rot_result = {r_value[6:0], carry_in};
        rot_carry = r_value[7];
        is_zero = (r_value == 8'h00);
    end
endmodule : move_rotate_unit

// ==== testbench/tb_mcu_move_return_rotate_ops.sv ====
/*
 * Self-checking bench for the move/return/rotate execution block, driven over its
 * instruction port and its AXI4-Lite control/status slave.
 * Assumes the default parameters and the register offsets of the shared constants header.
 */
`timescale 1ns/1ps
`include "ops_consts.svh"

module tb_mcu_move_return_rotate_ops;
    import core_ops_pkg::*;
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic instr_valid, instr_ready, instr_flush, instr_dest, global_interrupt_enable;
    op_t instr_op;
    logic [6:0] instr_reg;
    logic [7:0] instr_lit;
    logic [7:0] accumulator_reg;
    logic [10:0] pc;
    logic [10:0] pc_exp;
    int failures = 0;
    int total_checks = 0;

    mcu_exec_core dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .instr_valid(instr_valid), .instr_op(instr_op), .instr_reg(instr_reg),
        .instr_dest(instr_dest), .instr_lit(instr_lit), .instr_ready(instr_ready),
        .instr_flush(instr_flush), .pc(pc), .accumulator_reg(accumulator_reg),
        .global_interrupt_enable(global_interrupt_enable));

    // free-running 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task tally_and_finish;
        if (failures == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task timed_out(input string what);
        failures++;
        $display("MISMATCH at %0t: no answer in %s", $time, what);
        tally_and_finish();
    endtask : timed_out

    // one write; address and data offered together, bready held until bvalid is seen
    task bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        int n;
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (!(aw_done && w_done)) timed_out("write request");
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (bvalid) break;
        end
        if (n == 50) timed_out("write response");
        bready <= 1'b0;
        check(32'(bresp), 32'(exp_resp), "write response code");
    endtask : bus_write

    task bus_read(input logic [7:0] a, input logic [31:0] exp_data, input logic [1:0] exp_resp);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) break;
        end
        if (n == 50) timed_out("read request");
        arvalid <= 1'b0;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (rvalid) break;
        end
        if (n == 50) timed_out("read data");
        rready <= 1'b0;
        check(rdata, exp_data, "read data");
        check(32'(rresp), 32'(exp_resp), "read response code");
    endtask : bus_read

    // offer one instruction, hold it until taken, return in the cycle after the taking edge
    task issue(input op_t op, input logic [6:0] r, input logic d, input logic [7:0] lit);
        int n;
        @(posedge aclk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_reg <= r;
        instr_dest <= d;
        instr_lit <= lit;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (instr_ready) break;
        end
        if (n == 50) timed_out("instruction");
        instr_valid <= 1'b0;
        @(negedge aclk);
    endtask : issue

    // data registers have no reset and no bus path: feed a chosen carry into bit 0 eight times
    task set_reg(input logic [6:0] r, input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            bus_write(`OFS_STATUS, {31'h0, v[i]}, `RESP_OKAY);
            issue(rotate_left_through_carry, r, 1'b1, 8'h00);
        end
    endtask : set_reg

    task reset_and_map;
        check(32'(pc), 32'h0, "pc after reset");
        check(32'(accumulator_reg), 32'h0, "accumulator after reset");
        bus_read(`OFS_CTRL, 32'h1, `RESP_OKAY);
        bus_read(`OFS_STATUS, 32'h0, `RESP_OKAY);
        bus_read(8'h14, 32'h0, `RESP_SLVERR);
        bus_write(8'h14, 32'h0000_00ff, `RESP_SLVERR);
        bus_write(`OFS_ACC, 32'h0000_00ff, `RESP_SLVERR);
        check(32'(accumulator_reg), 32'h0, "read-only accumulator written");
    endtask : reset_and_map

    task load_and_nop;
        bus_write(`OFS_STATUS, 32'h3, `RESP_OKAY);
        pc_exp = pc;
        issue(load_immediate_to_acc, 7'h00, 1'b0, 8'hff);
        check(32'(accumulator_reg), 32'hff, "literal load");
        issue(load_immediate_to_acc, 7'h00, 1'b0, 8'h55);
        check(32'(accumulator_reg), 32'h55, "literal load back to back");
        issue(no_operation, 7'h00, 1'b0, 8'h00);
        check(32'(pc), 32'(pc_exp + 11'h3), "pc step");
        check(32'(accumulator_reg), 32'h55, "no-op accumulator");
        bus_read(`OFS_STATUS, 32'h3, `RESP_OKAY);
    endtask : load_and_nop

    task move_cases;
        set_reg(7'h09, 8'h00);
        set_reg(7'h05, 8'ha5);
        set_reg(7'h7f, 8'h01);
        bus_write(`OFS_STATUS, 32'h0, `RESP_OKAY);
        issue(move_register, 7'h09, 1'b1, 8'h00);
        check(32'(accumulator_reg), 32'h55, "move to register keeps accumulator");
        bus_read(`OFS_STATUS, 32'h2, `RESP_OKAY);
        issue(move_register, 7'h05, 1'b0, 8'h00);
        check(32'(accumulator_reg), 32'ha5, "move to accumulator");
        bus_read(`OFS_STATUS, 32'h0, `RESP_OKAY);
        issue(move_register, 7'h7f, 1'b0, 8'h00);
        check(32'(accumulator_reg), 32'h01, "move from top register");
        issue(move_register, 7'h09, 1'b0, 8'h00);
        check(32'(accumulator_reg), 32'h00, "move zero value");
        bus_read(`OFS_STATUS, 32'h2, `RESP_OKAY);
    endtask : move_cases

    task rotate_cases;
        bus_write(`OFS_STATUS, 32'h0, `RESP_OKAY);
        issue(rotate_left_through_carry, 7'h05, 1'b1, 8'h00);
        check(32'(accumulator_reg), 32'h00, "rotate to register keeps accumulator");
        bus_read(`OFS_STATUS, 32'h1, `RESP_OKAY);
        issue(move_register, 7'h05, 1'b0, 8'h00);
        check(32'(accumulator_reg), 32'h4a, "rotated register");
        bus_write(`OFS_STATUS, 32'h3, `RESP_OKAY);
        issue(rotate_left_through_carry, 7'h05, 1'b0, 8'h00);
        check(32'(accumulator_reg), 32'h95, "rotate into accumulator");
        bus_read(`OFS_STATUS, 32'h2, `RESP_OKAY);
        issue(move_register, 7'h05, 1'b0, 8'h00);
        check(32'(accumulator_reg), 32'h4a, "register untouched by accumulator rotate");
    endtask : rotate_cases

    task return_cases;
        bus_write(`OFS_STATUS, 32'h0, `RESP_OKAY);
        // push without byte 1 enabled must leave the stack alone
        wstrb <= 4'h1;
        bus_write(`OFS_PUSH, 32'h0000_0456, `RESP_OKAY);
        wstrb <= 4'hf;
        bus_write(`OFS_PUSH, 32'h0000_0123, `RESP_OKAY);
        bus_write(`OFS_PUSH, 32'h0000_07ff, `RESP_OKAY);
        bus_read(`OFS_STATUS, 32'h20, `RESP_OKAY);
        issue(return_enable_interrupts, 7'h00, 1'b0, 8'h00);
        check(32'(pc), 32'h7ff, "pc from stack top");
        check(32'(global_interrupt_enable), 32'h1, "interrupt enable set");
        check(32'({instr_flush, instr_ready}), 32'h2, "flush and bubble");
        @(negedge aclk);
        check(32'({instr_flush, instr_ready}), 32'h1, "flush ends");
        bus_read(`OFS_STATUS, 32'h14, `RESP_OKAY);
        bus_write(`OFS_STATUS, 32'h3, `RESP_OKAY);
        issue(return_with_literal, 7'h00, 1'b0, 8'h3c);
        check(32'(accumulator_reg), 32'h3c, "return literal");
        check(32'(pc), 32'h123, "pc from second entry");
        check(32'(instr_flush), 32'h1, "flush after literal return");
        bus_read(`OFS_STATUS, 32'h03, `RESP_OKAY);
        issue(no_operation, 7'h00, 1'b0, 8'h00);
        check(32'(pc), 32'h124, "execution resumes at popped address");
    endtask : return_cases

    task run_hold;
        bus_write(`OFS_CTRL, 32'h0, `RESP_OKAY);
        repeat (2) @(negedge aclk);
        check(32'(instr_ready), 32'h0, "stopped core refuses instructions");
        bus_write(`OFS_CTRL, 32'h1, `RESP_OKAY);
        issue(no_operation, 7'h00, 1'b0, 8'h00);
        check(32'(pc), 32'h125, "resumed core");
        bus_read(`OFS_PC, 32'h125, `RESP_OKAY);
        bus_read(`OFS_ACC, 32'h3c, `RESP_OKAY);
        bus_read(`OFS_PUSH, 32'h123, `RESP_OKAY);
    endtask : run_hold

    // main sequence: every input defined at time zero, reset held for six cycles
    initial begin
        aresetn = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hf;
        instr_valid = 1'b0;
        instr_op = no_operation;
        instr_reg = 7'h00;
        instr_dest = 1'b0;
        instr_lit = 8'h00;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(negedge aclk);
        reset_and_map();
        load_and_nop();
        move_cases();
        rotate_cases();
        return_cases();
        run_hold();
        tally_and_finish();
    end
endmodule : tb_mcu_move_return_rotate_ops
